// file: sim/sos_system_oscillator_select_checker.sv
`timescale 1ns/10ps
`include "sos_params.svh"

module sos_system_oscillator_select_checker (
  input wire logic                      mclk,
  input wire logic                      sys_rst,
  input wire logic                      cfgHighSpeedInternal,
  input wire logic [1:0]                cfgFastRcFreq,
  input wire logic                      crystalIn,
  input wire sos_pkg::sos_axi_req_type  axiReq,
  input wire sos_pkg::sos_axi_resp_type axiResp,
  input wire sos_pkg::sos_clk_out_type  clkOut
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////
  a_pins_free_gpio: assert property (clkOut.crystalPinsAsGpio |-> !clkOut.crystalOscEnable)
    else $error("crystal enabled while its pins are gpio");
  // straps may only settle on the first edges after reset
  a_straps_held: assert property (!$past(sys_rst) && !$past(sys_rst, 2) |-> $stable(clkOut.crystalPinsAsGpio))
    else $error("gpio flag moved outside reset");
  a_stopped_no_tick: assert property (!clkOut.crystalPinsAsGpio && !clkOut.crystalOscEnable |-> !clkOut.highSpeedClkEn)
    else $error("high speed tick while crystal stopped");
  a_slow_shared: assert property ((clkOut.substituteClkEn == clkOut.watchdogClkEn) && (clkOut.substituteClkEn == clkOut.timeBaseClkEn))
    else $error("watchdog or time base tick differs from slow tick");
  a_slow_spacing: assert property (clkOut.substituteClkEn |=> !clkOut.substituteClkEn [*8])
    else $error("slow ticks too close");
  a_fast_spacing: assert property (clkOut.highSpeedClkEn && clkOut.crystalPinsAsGpio |=> !clkOut.highSpeedClkEn [*2])
    else $error("fast rc ticks too close");
  a_xtal_tick_cause: assert property (clkOut.highSpeedClkEn && !clkOut.crystalPinsAsGpio |-> $past(crystalIn) || $past(crystalIn, 2))
    else $error("crystal tick without crystal edge");
  a_write_answer: assert property (axiReq.awvalid && axiResp.awready && axiReq.wvalid && axiResp.wready |-> ##[1:3] axiResp.bvalid)
    else $error("write response late");
  a_read_answer: assert property (axiReq.arvalid && axiResp.arready |=> axiResp.rvalid)
    else $error("read response late");
  a_read_holds: assert property (axiResp.rvalid && !axiReq.rready |=> axiResp.rvalid && $stable(axiResp.rdata))
    else $error("read data dropped before taken");
  cover property (clkOut.sysClkEn && clkOut.crystalOscEnable);
  cover property (clkOut.substituteClkEn && !clkOut.crystalPinsAsGpio && !clkOut.crystalOscEnable);
  cover property (axiResp.rvalid && axiResp.rresp == `SOS_RESP_SLVERR);
endmodule

bind sos_system_oscillator_select sos_system_oscillator_select_checker u_chk (.mclk, .sys_rst, .cfgHighSpeedInternal,
  .cfgFastRcFreq, .crystalIn, .axiReq, .axiResp, .clkOut);

// file: sim/sos_system_oscillator_select_tb.sv
`timescale 1ns/10ps
`include "sos_params.svh"
`define CHK(a, e) begin checksDone++; if ((a) !== (e)) begin errCount++; $display("BAD %0t got %h exp %h", $time, a, e); end end

module sos_system_oscillator_select_tb;
  logic                      mclk;
  logic                      sys_rst;
  logic                      cfgHighSpeedInternal;
  logic [1:0]                cfgFastRcFreq;
  wire logic                 crystalIn;
  logic [1:0]                xc = 2'h0;
  sos_pkg::sos_axi_req_type  axiReq;
  sos_pkg::sos_axi_resp_type axiResp;
  sos_pkg::sos_clk_out_type  clkOut;
  int                        errCount;
  int                        checksDone;
  int                        nSys;
  int                        nHs;
  int                        nSub;
  logic [1:0]                lv;
  logic [31:0]               rd;
  logic [1:0]                rs;

  sos_system_oscillator_select u_dut (.mclk, .sys_rst, .cfgHighSpeedInternal, .cfgFastRcFreq, .crystalIn,
    .axiReq, .axiResp, .clkOut);

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // crystal at a quarter of mclk, 10 MHz, inside the allowed span
  always @(posedge mclk) xc <= xc + 2'h1;
  assign crystalIn = xc[1];
  ////////////////////////////////////////////////////////////////
  function automatic logic near(int n, int e);
    return (n >= e - 1) && (n <= e + 1);
  endfunction

  task automatic doReset(input logic hs, input logic [1:0] fr);
    sys_rst <= 1'b1;
    cfgHighSpeedInternal <= hs;
    cfgFastRcFreq <= fr;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic axWrite(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    logic aw, w, ga, gw;
    aw = 1'b1;
    w = 1'b1;
    axiReq.awvalid <= 1'b1;
    axiReq.awaddr <= a;
    axiReq.wvalid <= 1'b1;
    axiReq.wdata <= d;
    axiReq.wstrb <= s;
    while (aw || w) begin
      @(negedge mclk);
      ga = axiResp.awready;
      gw = axiResp.wready;
      @(posedge mclk);
      if (ga) begin
        aw = 1'b0;
        axiReq.awvalid <= 1'b0;
      end
      if (gw) begin
        w = 1'b0;
        axiReq.wvalid <= 1'b0;
      end
    end
    do @(negedge mclk); while (axiResp.bvalid !== 1'b1);
    r = axiResp.bresp;
    @(posedge mclk);
  endtask

  task automatic axRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    axiReq.arvalid <= 1'b1;
    axiReq.araddr <= a;
    do @(negedge mclk); while (axiResp.arready !== 1'b1);
    @(posedge mclk);
    axiReq.arvalid <= 1'b0;
    do @(negedge mclk); while (axiResp.rvalid !== 1'b1);
    d = axiResp.rdata;
    r = axiResp.rresp;
    @(posedge mclk);
  endtask

  task automatic setMode(input logic spd, input logic [2:0] dv);
    axWrite(`SOS_OFS_MODE, {24'h0, dv, 4'h0, spd}, 4'hf, rs);
    `CHK(rs, `SOS_RESP_OKAY)
    repeat (4) @(posedge mclk);
  endtask

  // level flags kept from the last settled sample of the window
  task automatic countTicks(input int cyc);
    nSys = 0;
    nHs = 0;
    nSub = 0;
    repeat (cyc) begin
      @(negedge mclk);
      nSys += clkOut.sysClkEn;
      nHs += clkOut.highSpeedClkEn;
      // watchdog and time base must tick with the slow rc
      nSub += clkOut.substituteClkEn & clkOut.watchdogClkEn & clkOut.timeBaseClkEn;
      lv = {clkOut.crystalPinsAsGpio, clkOut.crystalOscEnable};
    end
    @(posedge mclk);
  endtask

  task automatic finishTest;
    $display("checks %0d mismatches %0d", checksDone, errCount);
    if (errCount == 0 && checksDone > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    // about 80k cycles; the tests need about 60k
    #2000000;
    errCount++;
    finishTest();
  end

  initial begin
    errCount = 0;
    checksDone = 0;
    axiReq = '0;
    axiReq.bready = 1'b1;
    axiReq.rready = 1'b1;
    for (int f = 0; f < 4; f++) begin
      doReset(1'b1, f[1:0]);
      axRead(`SOS_OFS_MODE, rd, rs);
      `CHK(rd, 32'h0000_0001)
      axRead(`SOS_OFS_STATUS, rd, rs);
      `CHK(rd[4:0], {f[1:0], 3'b111})
      countTicks(1200);
      `CHK(lv, 2'b10)
      `CHK(near(nSys, 30 * ((f == 1) ? 8 : (f == 2) ? 12 : 4)), 1'b1)
      `CHK(near(nHs, 30 * ((f == 1) ? 8 : (f == 2) ? 12 : 4)), 1'b1)
    end
    $display("test fast rc done");
    doReset(1'b1, 2'h0);
    for (int c = 0; c < 8; c++) begin
      setMode(1'b0, c[2:0]);
      countTicks(6400);
      if (c >= 2 && c <= 6) begin
        `CHK(near(nSys, 640 >> (8 - c)), 1'b1)
      end else begin
        `CHK(near(nSys, 5), 1'b1)
        `CHK(nHs, 0)
        axRead(`SOS_OFS_STATUS, rd, rs);
        `CHK(rd[1:0], 2'b00)
      end
      `CHK(near(nSub, 5), 1'b1)
    end
    $display("test divider done");
    doReset(1'b0, 2'h0);
    countTicks(400);
    `CHK(near(nSys, 100), 1'b1)
    `CHK(lv, 2'b01)
    setMode(1'b0, `SOS_DIV_SUB0);
    countTicks(400);
    `CHK(nHs, 0)
    `CHK(lv, 2'b00)
    $display("test crystal done");
    axRead(8'h08, rd, rs);
    `CHK({rs, rd}, {`SOS_RESP_SLVERR, 32'h0})
    axWrite(8'h08, 32'hffff_ffff, 4'hf, rs);
    `CHK(rs, `SOS_RESP_SLVERR)
    axWrite(`SOS_OFS_STATUS, 32'hffff_ffff, 4'hf, rs);
    `CHK(rs, `SOS_RESP_OKAY)
    axRead(`SOS_OFS_MODE, rd, rs);
    `CHK(rd, 32'h0000_0000)
    setMode(1'b1, `SOS_DIV_4);
    axRead(`SOS_OFS_MODE, rd, rs);
    `CHK(rd, 32'h0000_00c1)
    // lane 0 strobe off: mode must keep its value
    axWrite(`SOS_OFS_MODE, 32'h0, 4'he, rs);
    `CHK(rs, `SOS_RESP_OKAY)
    axRead(`SOS_OFS_MODE, rd, rs);
    `CHK(rd, 32'h0000_00c1)
    countTicks(400);
    `CHK(near(nSys, 100), 1'b1)
    $display("test bus done");
    finishTest();
  end
endmodule

// file: src/sos_params.svh
`ifndef SOS_PARAMS_SVH
`define SOS_PARAMS_SVH

// bus geometry
`define SOS_ADDR_W        8
`define SOS_DATA_W        32
`define SOS_STRB_W        4

// register byte offsets
`define SOS_OFS_MODE      8'h00
`define SOS_OFS_STATUS    8'h04

// mode register fields
`define SOS_MODE_SPD_BIT  0
`define SOS_MODE_DIV_LSB  5
`define SOS_MODE_DIV_MSB  7
`define SOS_MODE_SPD_RST  1'h1
`define SOS_MODE_DIV_RST  3'h0

// status register fields
`define SOS_ST_HSON_BIT   0
`define SOS_ST_HSSYS_BIT  1
`define SOS_ST_CFGHS_BIT  2
`define SOS_ST_FRQ_LSB    3
`define SOS_ST_FRQ_MSB    4

// divider codes
`define SOS_DIV_SUB0      3'h0
`define SOS_DIV_SUB1      3'h1
`define SOS_DIV_64        3'h2
`define SOS_DIV_32        3'h3
`define SOS_DIV_16        3'h4
`define SOS_DIV_8         3'h5
`define SOS_DIV_4         3'h6

// divider terminal counts, one pulse per 64/32/16/8/4 ticks
`define SOS_TERM_64       6'h3f
`define SOS_TERM_32       6'h1f
`define SOS_TERM_16       6'h0f
`define SOS_TERM_8        6'h07
`define SOS_TERM_4        6'h03
`define SOS_TERM_NONE     6'h00

// fast rc frequency codes
`define SOS_FRQ_4         2'h0
`define SOS_FRQ_8         2'h1
`define SOS_FRQ_12        2'h2

// timing, in MHz and kHz, and accumulator and counter widths in bits
`define SOS_MCLK_MHZ      40
`define SOS_MCLK_KHZ      40000
`define SOS_SLOW_KHZ      32
`define SOS_FAST_4_MHZ    4
`define SOS_FAST_8_MHZ    8
`define SOS_FAST_12_MHZ   12
`define SOS_FAST_ACC_W    6
`define SOS_SLOW_ACC_W    16
`define SOS_DIVCNT_W      6

// bus responses
`define SOS_RESP_OKAY     2'h0
`define SOS_RESP_SLVERR   2'h2

`endif

// file: src/sos_pkg.sv
`include "sos_params.svh"

package sos_pkg;

  typedef struct packed {
    logic                    awvalid;
    logic [`SOS_ADDR_W-1:0]  awaddr;
    logic                    wvalid;
    logic [`SOS_DATA_W-1:0]  wdata;
    logic [`SOS_STRB_W-1:0]  wstrb;
    logic                    bready;
    logic                    arvalid;
    logic [`SOS_ADDR_W-1:0]  araddr;
    logic                    rready;
  } sos_axi_req_type;

  typedef struct packed {
    logic                    awready;
    logic                    wready;
    logic                    bvalid;
    logic [1:0]              bresp;
    logic                    arready;
    logic                    rvalid;
    logic [`SOS_DATA_W-1:0]  rdata;
    logic [1:0]              rresp;
  } sos_axi_resp_type;

  typedef struct packed {
    logic                    sysClkEn;
    logic                    highSpeedClkEn;
    logic                    substituteClkEn;
    logic                    watchdogClkEn;
    logic                    timeBaseClkEn;
    logic                    crystalOscEnable;
    logic                    crystalPinsAsGpio;
  } sos_clk_out_type;

  typedef struct packed {
    logic [2:0]                  clockDividerSelect;
    logic                        clockSpeedSelect;
    logic                        cfgHsInternal;
    logic [1:0]                  cfgFastFreq;
    logic [`SOS_FAST_ACC_W-1:0]  fastAcc;
    logic [`SOS_SLOW_ACC_W-1:0]  slowAcc;
    logic                        crystalPrev;
    logic [`SOS_DIVCNT_W-1:0]    divCnt;
    logic                        awHave;
    logic [`SOS_ADDR_W-1:0]      awAddr;
    logic                        wHave;
    logic [`SOS_DATA_W-1:0]      wData;
    logic [`SOS_STRB_W-1:0]      wStrb;
    logic                        bvalid;
    logic [1:0]                  bresp;
    logic                        rvalid;
    logic [`SOS_DATA_W-1:0]      rdata;
    logic [1:0]                  rresp;
    sos_clk_out_type             clk;
  } sos_state_type;

endpackage

// file: src/sos_system_oscillator_select.sv
// The register offsets and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/10ps
`include "sos_params.svh"

module sos_system_oscillator_select (
  input  wire logic                     mclk,
  input  wire logic                     sys_rst,
  input  wire logic                     cfgHighSpeedInternal,
  input  wire logic [1:0]               cfgFastRcFreq,
  input  wire logic                     crystalIn,
  input  wire sos_pkg::sos_axi_req_type axiReq,
  output sos_pkg::sos_axi_resp_type     axiResp,
  output sos_pkg::sos_clk_out_type      clkOut
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // terminal count of the high speed divider
  function automatic logic [`SOS_DIVCNT_W-1:0] divTerm(input logic [2:0] code);
    case (code)
      `SOS_DIV_64: divTerm = `SOS_TERM_64;
      `SOS_DIV_32: divTerm = `SOS_TERM_32;
      `SOS_DIV_16: divTerm = `SOS_TERM_16;
      `SOS_DIV_8:  divTerm = `SOS_TERM_8;
      `SOS_DIV_4:  divTerm = `SOS_TERM_4;
      default:     divTerm = `SOS_TERM_NONE;
    endcase
  endfunction

  // code 7 undocumented, treated as substitute like 0 and 1
  function automatic logic divUsesHigh(input logic [2:0] code);
    divUsesHigh = (code >= `SOS_DIV_64) && (code <= `SOS_DIV_4);
  endfunction

  // fast rc step in MHz; code 3 falls back to 4 MHz so no value is empty
  function automatic logic [`SOS_FAST_ACC_W-1:0] fastStep(input logic [1:0] code);
    case (code)
      `SOS_FRQ_8:  fastStep = `SOS_FAST_ACC_W'(`SOS_FAST_8_MHZ);
      `SOS_FRQ_12: fastStep = `SOS_FAST_ACC_W'(`SOS_FAST_12_MHZ);
      default:     fastStep = `SOS_FAST_ACC_W'(`SOS_FAST_4_MHZ);
    endcase
  endfunction

  function automatic logic isMapped(input logic [`SOS_ADDR_W-1:0] a);
    isMapped = (a == `SOS_OFS_MODE) || (a == `SOS_OFS_STATUS);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  sos_pkg::sos_state_type st_reg;
  sos_pkg::sos_state_type st_next;

  logic                        hsOn;
  logic                        hsSys;
  logic                        fastTick;
  logic                        slowTick;
  logic                        crystalTick;
  logic                        hsTick;
  logic                        divPulse;
  logic [`SOS_FAST_ACC_W:0]    fastSum;
  logic [`SOS_SLOW_ACC_W:0]    slowSum;
  logic                        doWrite;
  logic [`SOS_DATA_W-1:0]      modeWord;
  logic [`SOS_DATA_W-1:0]      statusWord;

  always_comb begin
    st_next = st_reg;

    hsSys = st_reg.clockSpeedSelect | divUsesHigh(st_reg.clockDividerSelect);
    hsOn  = hsSys;

    // fractional accumulators keep 12 MHz and 32 kHz exact on average
    fastSum  = {1'b0, st_reg.fastAcc} + {1'b0, fastStep(st_reg.cfgFastFreq)};
    fastTick = 1'b0;
    if (hsOn && st_reg.cfgHsInternal) begin
      if (fastSum >= (`SOS_FAST_ACC_W+1)'(`SOS_MCLK_MHZ)) begin
        fastTick       = 1'b1;
        st_next.fastAcc = `SOS_FAST_ACC_W'(fastSum - (`SOS_FAST_ACC_W+1)'(`SOS_MCLK_MHZ));
      end else begin
        st_next.fastAcc = fastSum[`SOS_FAST_ACC_W-1:0];
      end
    end

    // slow rc never stops: watchdog and time base depend on it
    slowSum  = {1'b0, st_reg.slowAcc} + (`SOS_SLOW_ACC_W+1)'(`SOS_SLOW_KHZ);
    slowTick = 1'b0;
    if (slowSum >= (`SOS_SLOW_ACC_W+1)'(`SOS_MCLK_KHZ)) begin
      slowTick        = 1'b1;
      st_next.slowAcc = `SOS_SLOW_ACC_W'(slowSum - (`SOS_SLOW_ACC_W+1)'(`SOS_MCLK_KHZ));
    end else begin
      st_next.slowAcc = slowSum[`SOS_SLOW_ACC_W-1:0];
    end

    // crystal up to 12 MHz stays well under half of mclk
    st_next.crystalPrev = crystalIn;
    crystalTick = hsOn && !st_reg.cfgHsInternal && crystalIn && !st_reg.crystalPrev;

    hsTick = st_reg.cfgHsInternal ? fastTick : crystalTick;

    divPulse = 1'b0;
    if (!hsOn) begin
      st_next.divCnt = '0;
    end else if (hsTick) begin
      if (st_reg.divCnt >= divTerm(st_reg.clockDividerSelect)) begin
        divPulse       = 1'b1;
        st_next.divCnt = '0;
      end else begin
        st_next.divCnt = st_reg.divCnt + `SOS_DIVCNT_W'(1);
      end
    end

    // clock enables, registered
    if (st_reg.clockSpeedSelect) begin
      st_next.clk.sysClkEn = hsTick;
    end else if (divUsesHigh(st_reg.clockDividerSelect)) begin
      st_next.clk.sysClkEn = divPulse;
    end else begin
      st_next.clk.sysClkEn = slowTick;
    end
    st_next.clk.highSpeedClkEn    = hsOn & hsTick;
    st_next.clk.substituteClkEn   = slowTick;
    st_next.clk.watchdogClkEn     = slowTick;
    st_next.clk.timeBaseClkEn     = slowTick;
    st_next.clk.crystalOscEnable  = hsOn & !st_reg.cfgHsInternal;
    st_next.clk.crystalPinsAsGpio = st_reg.cfgHsInternal;

    // straps follow the pins while reset is high, latched at release
    if (sys_rst) begin
      st_next.cfgHsInternal = cfgHighSpeedInternal;
      st_next.cfgFastFreq   = cfgFastRcFreq;
    end

    ////////////////////////////////////////////////////////////////////////////
    // axi4-lite slave

    modeWord = '0;
    modeWord[`SOS_MODE_DIV_MSB:`SOS_MODE_DIV_LSB] = st_reg.clockDividerSelect;
    modeWord[`SOS_MODE_SPD_BIT]                   = st_reg.clockSpeedSelect;
    statusWord = '0;
    statusWord[`SOS_ST_HSON_BIT]  = hsOn;
    statusWord[`SOS_ST_HSSYS_BIT] = hsSys;
    statusWord[`SOS_ST_CFGHS_BIT] = st_reg.cfgHsInternal;
    statusWord[`SOS_ST_FRQ_MSB:`SOS_ST_FRQ_LSB] = st_reg.cfgFastFreq;

    axiResp.awready = !st_reg.awHave && !st_reg.bvalid;
    axiResp.wready  = !st_reg.wHave && !st_reg.bvalid;
    axiResp.bvalid  = st_reg.bvalid;
    axiResp.bresp   = st_reg.bresp;
    axiResp.arready = !st_reg.rvalid;
    axiResp.rvalid  = st_reg.rvalid;
    axiResp.rdata   = st_reg.rdata;
    axiResp.rresp   = st_reg.rresp;

    if (axiReq.awvalid && axiResp.awready) begin
      st_next.awHave = 1'b1;
      st_next.awAddr = axiReq.awaddr;
    end
    if (axiReq.wvalid && axiResp.wready) begin
      st_next.wHave = 1'b1;
      st_next.wData = axiReq.wdata;
      st_next.wStrb = axiReq.wstrb;
    end

    doWrite = st_reg.awHave && st_reg.wHave;
    if (doWrite) begin
      st_next.awHave = 1'b0;
      st_next.wHave  = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp  = isMapped(st_reg.awAddr) ? `SOS_RESP_OKAY : `SOS_RESP_SLVERR;
      // mode fields live in byte lane 0; status is read only
      if (st_reg.awAddr == `SOS_OFS_MODE && st_reg.wStrb[0]) begin
        st_next.clockDividerSelect = st_reg.wData[`SOS_MODE_DIV_MSB:`SOS_MODE_DIV_LSB];
        st_next.clockSpeedSelect   = st_reg.wData[`SOS_MODE_SPD_BIT];
      end
    end
    if (st_reg.bvalid && axiReq.bready) begin
      st_next.bvalid = 1'b0;
    end

    if (axiReq.arvalid && axiResp.arready) begin
      st_next.rvalid = 1'b1;
      st_next.rresp  = isMapped(axiReq.araddr) ? `SOS_RESP_OKAY : `SOS_RESP_SLVERR;
      case (axiReq.araddr)
        `SOS_OFS_MODE:   st_next.rdata = modeWord;
        `SOS_OFS_STATUS: st_next.rdata = statusWord;
        default:         st_next.rdata = '0;
      endcase
    end else if (st_reg.rvalid && axiReq.rready) begin
      st_next.rvalid = 1'b0;
    end

    clkOut = st_reg.clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_reg                    <= '0;
      st_reg.clockSpeedSelect   <= `SOS_MODE_SPD_RST;
      st_reg.clockDividerSelect <= `SOS_MODE_DIV_RST;
      // straps still follow the pins while reset is held
      st_reg.cfgHsInternal      <= st_next.cfgHsInternal;
      st_reg.cfgFastFreq        <= st_next.cfgFastFreq;
      // track the pin so a high crystal gives no false edge at release
      st_reg.crystalPrev        <= st_next.crystalPrev;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule
